//--- core/fpq_pkg.sv
// Constants shared by the flash protect/accel/query host controller.
// Assumes a 125 MHz core clock and an asynchronous parallel NOR flash outside.
`default_nettype none
package fpq_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// Strobe widths and settle time of the flash bus, chosen generously
	localparam int STROBE_TIME_NS = 80;
	localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_TIME_NS = 500;
	localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam logic [7:0] QUERY_CMD = 8'h98;
	localparam logic [7:0] RESET_CMD = 8'hf0;
	localparam logic [ADDR_W-1:0] QUERY_WORD_ADDR = 21'h000055;
	localparam logic [ADDR_W-1:0] QUERY_BYTE_ADDR = 21'h0000aa;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;
	localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] PROGRAM_CMD = 8'ha0;
	localparam logic [7:0] QRY_FIRST = 8'h10;
	localparam logic [7:0] QRY_LAST = 8'h29;
	// Pin level codes for protect_accel_pin
	localparam logic [1:0] PIN_LOW = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_ACCEL = 2'h2;
	typedef enum logic [2:0] {FPQ_OP_READ, FPQ_OP_QUERY_ENTER, FPQ_OP_QUERY_READ, FPQ_OP_RESET,
		FPQ_OP_PROGRAM, FPQ_OP_ACCEL_ON, FPQ_OP_ACCEL_OFF} fpq_op_t;
endpackage
`default_nettype wire

//--- core/fpq_host.sv
// Host controller driving flash pins: reads, programs, query reads and accel.
// Assumes a single requester on the same clock; flash data pins are tri-state.
// Operation
// RULE1 - Protect pin low makes device ignore writes to outer boot sectors.
// RULE2 - Protect pin high restores boot sectors' stored protection state.
// RULE3 - Accel high voltage puts device in shortcut program mode.
// RULE4 - While accelerated, host programs with the two-write sequence.
// RULE5 - Leaving high voltage returns device to normal handling.
// RULE6 - Host raises high voltage only from array read mode.
// RULE7 - Host holds high voltage only for accelerated programming.
// RULE8 - Ident voltage on reset pin temporarily unprotects sector groups.
// RULE9 - Removing ident voltage reprotects previously protected groups.
// RULE10 - Outer boot sectors stay protected in unprotect if pin low.
// RULE11 - Query command 98h at word 55h or byte AAh enters query.
// RULE12 - Word mode query reads drive address bits A7 upward to zero.
// RULE13 - Host ends query with reset command; device returns to array read.
// RULE14 - Query accepted in identification mode; reset returns there.
// RULE15 - Query words 10h-12h read Q, R, Y.
// RULE16 - Byte query address is twice word address; upper byte zero.
// RULE17 - Words 13h,14h give primary command set 0002h.
// RULE18 - Words 15h,16h point extended table at 40h.
// RULE19 - Words 17h-1Ah read zero.
// RULE20 - Words 1Bh-1Eh give supply range then zeros.
// RULE21 - Words 1Fh-22h give typical timing exponents.
// RULE22 - Words 23h-26h give maximum timing multipliers.
// RULE23 - Word 27h gives size, 28h-29h interface code.
`default_nettype none
module fpq_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire fpq_pkg::fpq_op_t req_op,
	input wire logic [fpq_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fpq_pkg::DATA_W-1:0] req_data,
	input wire logic byte_mode,
	// Answer
	output logic rsp_valid,
	output logic [fpq_pkg::DATA_W-1:0] rsp_data,
	output logic accel_active,
	output logic query_active,
	// Flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [fpq_pkg::ADDR_W-1:0] flash_addr,
	output logic [fpq_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [fpq_pkg::DATA_W-1:0] flash_dq_in,
	output logic [1:0] protect_accel_pin,
	output logic write_protect_on
);
	import fpq_pkg::*;

	typedef enum logic [2:0] {FPQ_IDLE, FPQ_WRITE, FPQ_GAP, FPQ_READ, FPQ_RAMP} fpq_state_t;

	fpq_state_t state;
	logic [CNT_W-1:0] count;
	logic [1:0] step;
	logic [1:0] steps_left;
	fpq_op_t op;
	logic [ADDR_W-1:0] op_addr;
	logic [DATA_W-1:0] op_data;
	logic dq_sync1;
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;
	logic in_query;

	// Query address: word form, or doubled for byte mode
	function automatic logic [ADDR_W-1:0] qaddr(input logic [ADDR_W-1:0] a, input logic bm);
		qaddr = bm ? {a[ADDR_W-2:0], 1'b0} : a;
	endfunction

	wire cnt_done = (count == '0);
	wire is_prog = (op == FPQ_OP_PROGRAM);
	// Accel may only be raised from array read, outside query; host tracks query mode
	wire accel_allowed = !in_query; // RULE6
	// Accel voltage serves programming only, so other work is refused while it is on
	wire accel_op_ok = (req_op == FPQ_OP_PROGRAM) || (req_op == FPQ_OP_ACCEL_OFF) || (req_op == FPQ_OP_ACCEL_ON); // RULE7
	// Plain reads in query would put high address bits on the pins
	wire req_ok = accel_active ? accel_op_ok :
		(req_op == FPQ_OP_ACCEL_ON) ? accel_allowed :
		(req_op == FPQ_OP_QUERY_READ) ? in_query :
		(req_op == FPQ_OP_READ) ? !in_query : 1'b1; // RULE12
	wire take = req_valid && req_ready && req_ok;
	assign req_ready = (state == FPQ_IDLE);
	assign query_active = in_query;
	assign accel_active = (protect_accel_pin == PIN_ACCEL);
	assign write_protect_on = (protect_accel_pin == PIN_LOW); // RULE1

	// Write cycle address/data per step of the sequence
	wire [ADDR_W-1:0] prog_addr = accel_active ? op_addr :
		(step == 2'h0) ? UNLOCK_ADDR1 : (step == 2'h1) ? UNLOCK_ADDR2 : (step == 2'h2) ? UNLOCK_ADDR1 : op_addr;
	wire [DATA_W-1:0] prog_data = accel_active ? ((step == 2'h0) ? {8'h00, PROGRAM_CMD} : op_data) : // RULE4
		(step == 2'h0) ? {8'h00, UNLOCK_DATA1} : (step == 2'h1) ? {8'h00, UNLOCK_DATA2} :
		(step == 2'h2) ? {8'h00, PROGRAM_CMD} : op_data;
	wire [ADDR_W-1:0] next_addr = is_prog ? prog_addr :
		(op == FPQ_OP_QUERY_ENTER) ? (byte_mode ? QUERY_BYTE_ADDR : QUERY_WORD_ADDR) : op_addr; // RULE11
	wire [DATA_W-1:0] next_data = is_prog ? prog_data :
		(op == FPQ_OP_QUERY_ENTER) ? {8'h00, QUERY_CMD} : {8'h00, RESET_CMD}; // RULE13
	// Word-mode query reads keep A7 and up at zero
	wire [ADDR_W-1:0] rd_addr = (req_op == FPQ_OP_QUERY_READ) ?
		qaddr({{(ADDR_W-7){1'b0}}, req_addr[6:0]}, byte_mode) : req_addr; // RULE12 RULE16
	wire [1:0] prog_steps = accel_active ? 2'h1 : 2'h3;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dq_meta <= '0;
			dq_sync <= '0;
			dq_sync1 <= 1'b0;
		end else begin
			dq_meta <= flash_dq_in;
			dq_sync <= dq_meta;
			dq_sync1 <= (state == FPQ_READ) && cnt_done;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= FPQ_IDLE;
			count <= '0;
			step <= '0;
			steps_left <= '0;
			op <= FPQ_OP_READ;
			op_addr <= '0;
			op_data <= '0;
			in_query <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
			protect_accel_pin <= PIN_HIGH; // RULE2
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= 1'b0;
			count <= cnt_done ? count : count - 1'b1;
			case (state)
				FPQ_IDLE: begin
					if (take) begin
						op <= req_op;
						op_addr <= rd_addr;
						op_data <= req_data;
						step <= '0;
						count <= CNT_W'(STROBE_CYCLES);
						case (req_op)
							FPQ_OP_READ, FPQ_OP_QUERY_READ: begin
								state <= FPQ_READ;
								flash_addr <= rd_addr;
								flash_ce_n <= 1'b0;
								flash_oe_n <= 1'b0;
							end
							FPQ_OP_ACCEL_ON: begin
								state <= FPQ_RAMP;
								protect_accel_pin <= PIN_ACCEL; // RULE3
								count <= CNT_W'(RAMP_CYCLES);
							end
							FPQ_OP_ACCEL_OFF: begin
								state <= FPQ_RAMP;
								protect_accel_pin <= req_data[0] ? PIN_HIGH : PIN_LOW; // RULE5 RULE7
								count <= CNT_W'(RAMP_CYCLES);
							end
							default: begin
								state <= FPQ_WRITE;
								steps_left <= (req_op == FPQ_OP_PROGRAM) ? prog_steps : 2'h0;
							end
						endcase
					end
				end
				FPQ_WRITE: begin
					flash_addr <= next_addr;
					flash_dq_out <= next_data;
					flash_dq_oe <= 1'b1;
					flash_ce_n <= 1'b0;
					flash_we_n <= cnt_done;
					if (cnt_done) begin
						state <= FPQ_GAP;
						count <= CNT_W'(STROBE_CYCLES);
					end
				end
				FPQ_GAP: begin
					flash_ce_n <= 1'b1;
					flash_we_n <= 1'b1;
					if (cnt_done) begin
						flash_dq_oe <= 1'b0;
						if (steps_left != 2'h0) begin
							steps_left <= steps_left - 2'h1;
							step <= step + 2'h1;
							state <= FPQ_WRITE;
							count <= CNT_W'(STROBE_CYCLES);
						end else begin
							state <= FPQ_IDLE;
							rsp_valid <= 1'b1;
							if (op == FPQ_OP_QUERY_ENTER)
								in_query <= 1'b1; // RULE14
							else if (op == FPQ_OP_RESET)
								in_query <= 1'b0; // RULE13
						end
					end
				end
				FPQ_READ: begin
					// Data sampled through the pin synchroniser after the strobe
					if (dq_sync1) begin
						flash_ce_n <= 1'b1;
						flash_oe_n <= 1'b1;
						rsp_data <= (op == FPQ_OP_QUERY_READ) ? {8'h00, dq_sync[7:0]} : dq_sync; // RULE16
						rsp_valid <= 1'b1;
						state <= FPQ_IDLE;
					end
				end
				FPQ_RAMP: begin
					// Pin level must settle slower than the ramp limit before use
					if (cnt_done) begin
						state <= FPQ_IDLE;
						rsp_valid <= 1'b1;
					end
				end
				default: state <= FPQ_IDLE;
			endcase
		end
	end
	// RULE8 RULE9 RULE10 RULE15 RULE17 RULE18 RULE19 RULE20 RULE21 RULE22 RULE23 are kept by the flash itself
endmodule // fpq_host
`default_nettype wire

//--- verification/fpq_checker.sv
// Port assertions for fpq_host.
// Assumes one core_clk domain and an async active-high reset.
`default_nettype none
module fpq_checker (
	// Clock, reset, status
	input wire logic core_clk, input wire logic reset, input wire logic rsp_valid,
	input wire logic accel_active, input wire logic query_active,
	// Flash pins
	input wire logic flash_ce_n, input wire logic flash_oe_n, input wire logic flash_we_n,
	input wire logic [fpq_pkg::ADDR_W-1:0] flash_addr, input wire logic [fpq_pkg::DATA_W-1:0] flash_dq_out,
	input wire logic flash_dq_oe, input wire logic [1:0] protect_accel_pin
);
	import fpq_pkg::*;
	logic [2:0] wr_cnt;
	logic [7:0] last_cmd;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Write strobes since the last answer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_cnt <= 3'h0;
			last_cmd <= 8'h0;
		end else begin
			wr_cnt <= rsp_valid ? 3'h0 : wr_cnt + 3'($fell(flash_we_n));
			last_cmd <= flash_we_n ? last_cmd : flash_dq_out[7:0];
		end
	end
	chk_accel_from_read: assert property (
		protect_accel_pin == PIN_ACCEL && $past(protect_accel_pin) != PIN_ACCEL |-> !query_active) else $error("bad accel");
	chk_accel_no_read: assert property (
		protect_accel_pin == PIN_ACCEL |-> flash_oe_n) else $error("read in accel");
	chk_accel_two_writes: assert property (
		rsp_valid && accel_active && wr_cnt != 3'h0 |-> wr_cnt == 3'h2) else $error("accel write count");
	chk_full_unlock: assert property (
		rsp_valid && !accel_active && wr_cnt > 3'h2 |-> wr_cnt == 3'h4) else $error("write count");
	chk_query_addr_low: assert property (
		query_active && !flash_oe_n |-> flash_addr[20:7] == 14'h0) else $error("query address");
	chk_query_exit_cmd: assert property (
		$fell(query_active) |-> last_cmd == RESET_CMD) else $error("query exit");
	chk_write_strobe: assert property (
		$fell(flash_we_n) |-> !flash_ce_n && flash_oe_n) else $error("write strobe");
	chk_read_no_drive: assert property (
		!flash_oe_n |-> !flash_dq_oe) else $error("bus clash");
endmodule // fpq_checker
bind fpq_host fpq_checker u_fpq_checker (.core_clk, .reset, .rsp_valid, .accel_active, .query_active, .flash_ce_n,
	.flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out, .flash_dq_oe, .protect_accel_pin);
`default_nettype wire

//--- verification/fpq_flash_model.sv
// Behavioural flash: array pattern reads and the query table.
// Assumes host pins directly; no reset pin, starts in array read.
`default_nettype none
module fpq_flash_model (
	// Host pins
	input wire logic flash_ce_n, input wire logic flash_oe_n, input wire logic flash_we_n, input wire logic byte_mode,
	input wire logic [20:0] flash_addr, input wire logic [15:0] flash_dq_out, output logic [15:0] flash_dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] QTAB [26] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0a, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h16, 8'h02, 8'h00};
	logic query_mode = 1'b0;
	logic [15:0] last_rd = 16'h0;
	logic [6:0] qword;
	logic [15:0] rd_val;
	assign qword = byte_mode ? flash_addr[7:1] : flash_addr[6:0];
	assign rd_val = !query_mode ? flash_addr[15:0] ^ 16'h5a5a : (qword >= 7'h10 && qword <= 7'h29) ?
		{8'h00, QTAB[qword - 7'h10]} : 16'h0;
	// Released bus shows the inverse, so a stale sample cannot match
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val : ~last_rd;
	always @(posedge flash_oe_n) last_rd <= rd_val;
	always @(posedge flash_we_n) begin
		if (!flash_ce_n && flash_dq_out[7:0] == 8'h98 && flash_addr == (byte_mode ? 21'haa : 21'h55)) begin
			query_mode <= 1'b1;
		end else if (!flash_ce_n && flash_dq_out[7:0] == 8'hf0) begin
			query_mode <= 1'b0;
		end
	end
endmodule // fpq_flash_model
`default_nettype wire

//--- verification/tb_fpq_host.sv
// Self-checking bench for fpq_host against the flash model.
// Assumes a single requester and the 125 MHz core clock.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value %0t: mismatch", $time); end end
module tb_fpq_host;
	timeunit 1ns;
	timeprecision 1ps;
	import fpq_pkg::*;
	localparam logic [7:0] EXP [26] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0a, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h16, 8'h02, 8'h00};
	logic core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, byte_mode = 1'b0;
	fpq_op_t req_op = FPQ_OP_READ;
	logic [20:0] req_addr = 21'h0, flash_addr;
	logic [15:0] req_data = 16'h0, rsp_data, flash_dq_out, flash_dq_in;
	logic req_ready, rsp_valid, accel_active, query_active, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
	logic write_protect_on;
	logic [1:0] protect_accel_pin;
	int fail_count = 0;
	int checks = 0;
	fpq_host u_fpq_host (.core_clk, .reset, .req_valid, .req_ready, .req_op, .req_addr, .req_data, .byte_mode,
		.rsp_valid, .rsp_data, .accel_active, .query_active, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
		.flash_dq_out, .flash_dq_oe, .flash_dq_in, .protect_accel_pin, .write_protect_on);
	fpq_flash_model u_fpq_flash_model (.flash_ce_n, .flash_oe_n, .flash_we_n, .byte_mode, .flash_addr,
		.flash_dq_out, .flash_dq_in);
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	task automatic test_done();
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Held until the host is ready; refused requests must stay unanswered
	task automatic run(input fpq_op_t op, input logic [20:0] a, input logic [15:0] d, input logic ans);
		int n;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_data <= d;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 300)
			fail_count++;
		@(posedge core_clk);
		req_valid <= 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		`CHK(rsp_valid, ans)
	endtask
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
	initial begin
		int i;
		int m;
		repeat (16) @(posedge core_clk);
		`CHK({protect_accel_pin, flash_ce_n, flash_we_n}, {PIN_HIGH, 2'h3})
		reset <= 1'b0;
		for (m = 0; m < 2; m++) begin
			@(posedge core_clk);
			byte_mode <= m[0];
			run(FPQ_OP_QUERY_ENTER, 21'h0, 16'h0, 1'b1);
			`CHK(query_active, 1'b1)
			for (i = 0; i < 26; i++) begin
				run(FPQ_OP_QUERY_READ, 21'(i + 16), 16'h0, 1'b1);
				`CHK(rsp_data, {8'h00, EXP[i]})
			end
			run(FPQ_OP_READ, 21'h1234, 16'h0, 1'b0);
			run(FPQ_OP_ACCEL_ON, 21'h0, 16'h0, 1'b0);
			`CHK(protect_accel_pin, PIN_HIGH)
			run(FPQ_OP_RESET, 21'h0, 16'h0, 1'b1);
			`CHK(query_active, 1'b0)
		end
		run(FPQ_OP_READ, 21'h1234, 16'h0, 1'b1);
		`CHK(rsp_data, 16'h1234 ^ 16'h5a5a)
		run(FPQ_OP_PROGRAM, 21'h100, 16'hbeef, 1'b1);
		run(FPQ_OP_ACCEL_ON, 21'h0, 16'h0, 1'b1);
		`CHK({protect_accel_pin, accel_active}, {PIN_ACCEL, 1'b1})
		run(FPQ_OP_READ, 21'h1234, 16'h0, 1'b0);
		run(FPQ_OP_PROGRAM, 21'h101, 16'h1234, 1'b1);
		run(FPQ_OP_ACCEL_OFF, 21'h0, 16'h0, 1'b1);
		`CHK({protect_accel_pin, write_protect_on}, {PIN_LOW, 1'b1})
		run(FPQ_OP_ACCEL_OFF, 21'h0, 16'h1, 1'b1);
		`CHK({protect_accel_pin, write_protect_on}, {PIN_HIGH, 1'b0})
		// Reset while idle inside query, after the entry is answered: host forgets the mode, the flash needs the reset command
		run(FPQ_OP_QUERY_ENTER, 21'h0, 16'h0, 1'b1);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		`CHK({query_active, protect_accel_pin, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe}, {1'b0, PIN_HIGH, 4'he})
		reset <= 1'b0;
		run(FPQ_OP_RESET, 21'h0, 16'h0, 1'b1);
		run(FPQ_OP_READ, 21'h0042, 16'h0, 1'b1);
		`CHK(rsp_data, 16'h0042 ^ 16'h5a5a)
		test_done();
	end
endmodule // tb_fpq_host
`default_nettype wire
